// ---- core/rpsm_cfg.svh ----
`ifndef RPSM_CFG_SVH
`define RPSM_CFG_SVH

// ==========================================================
// Register map (word index; byte address is index times four)
`define RPSM_NUM_REGS 15
`define RPSM_IDX_W 4
`define RPSM_ADDR_LSB 2
`define RPSM_IDX_SS 4'h0
`define RPSM_IDX_CAN 4'h1
`define RPSM_IDX_SYNC 4'h2
`define RPSM_IDX_DTA 4'h3
`define RPSM_IDX_DTB 4'h4
`define RPSM_IDX_OUT0 4'h5
`define RPSM_IDX_OUT7 4'hC
`define RPSM_IDX_OUT8 4'hD
`define RPSM_IDX_OUT9 4'hE
`define RPSM_REG_RESET 16'h0000

// ==========================================================
// Field layout
`define RPSM_LO_LSB 0
`define RPSM_HI_LSB 8
`define RPSM_MASK_LO_IN 16'h007F
`define RPSM_MASK_HI_IN 16'h7F00
`define RPSM_MASK_BOTH_IN 16'h7F7F
`define RPSM_MASK_OUT_PAIR 16'h3F3F
`define RPSM_MASK_OUT_HI 16'h3F00
`define RPSM_MASK_OUT_LO 16'h003F
`define RPSM_MASK_NONE 16'h0000

// ==========================================================
// Select codes and pin counts
`define RPSM_CODE_GND 7'h00
`define RPSM_CODE_CMP 7'h01
`define RPSM_CODE_PIN_MAX 7'h79
`define RPSM_OUT_CODE_OFF 6'h00
`define RPSM_IN_SRC_N 122
`define RPSM_OUT_FUNC_N 64
`define RPSM_OUT_PINS 17
`define RPSM_PAIRED_PINS 14
`define RPSM_PIN_97 14
`define RPSM_PIN_118 15
`define RPSM_PIN_120 16

`endif

// ---- core/rpsm_pkg.sv ----
`default_nettype none
package rpsm_pkg;
   typedef logic [15:0] rpsm_word_t;
   typedef logic [6:0] rpsm_in_sel_t;
   typedef logic [5:0] rpsm_out_sel_t;
   typedef logic [3:0] rpsm_idx_t;
   // Routed peripheral inputs, in port order
   typedef enum {RPSM_IN_SS, RPSM_IN_CAN, RPSM_IN_SYNC, RPSM_IN_DT1, RPSM_IN_DT2, RPSM_IN_DT3,
      RPSM_IN_COUNT} rpsm_in_t;
endpackage
`default_nettype wire

// ---- core/rpsm_sel_mux.sv ----
`default_nettype none
module rpsm_sel_mux
#(
   parameter int SEL_W = 7,
   parameter int SRC_N = 122
)
(
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic [SEL_W-1:0] sel,
   input wire logic [SRC_N-1:0] src,
   output logic outBit,
   output logic selActive
);
   initial
   begin
      if (SRC_N < 2 || SRC_N > (1 << SEL_W))
         $error("rpsm_sel_mux: SRC_N does not fit SEL_W");
   end

   logic outBit_next;

   // Codes past the source list read as ground
   always_comb
   begin
      outBit_next = 1'b0;
      if (int'(sel) < SRC_N)
         outBit_next = src[sel];
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         outBit <= 1'b0;
         selActive <= 1'b0;
      end
      else
      begin
         outBit <= outBit_next;
         selActive <= |sel;
      end
   end
endmodule
`default_nettype wire

// ---- core/rpsm_top.sv ----
`include "rpsm_cfg.svh"
`default_nettype none
module rpsm_top
   import rpsm_pkg::*;
#(
   parameter int ADDR_W = 12,
   parameter bit HAS_CAN = 1'b1,
   parameter int IN_SRC_N = `RPSM_IN_SRC_N,
   parameter int OUT_FUNC_N = `RPSM_OUT_FUNC_N
)
(
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [IN_SRC_N-1:0] remappablePinIn,
   input wire logic comparatorOneOutput,
   input wire logic [OUT_FUNC_N-1:0] peripheralFunctionOut,
   output logic serialTwoSlaveSelect,
   output logic canReceiveInput,
   output logic pwmSyncInputOne,
   output logic deadtimeCompInputOne,
   output logic deadtimeCompInputTwo,
   output logic deadtimeCompInputThree,
   output logic [`RPSM_OUT_PINS-1:0] remappablePinOut,
   output logic [`RPSM_OUT_PINS-1:0] remappablePinOutEn
);
   // ==========================================================
   // Elaboration checks
   initial
   begin
      if (ADDR_W < `RPSM_IDX_W + `RPSM_ADDR_LSB)
         $error("rpsm_top: ADDR_W too small for the register map");
      if (IN_SRC_N != int'(`RPSM_CODE_PIN_MAX) + 1)
         $error("rpsm_top: IN_SRC_N must cover codes up to pin 121");
      if (OUT_FUNC_N != (1 << 6))
         $error("rpsm_top: OUT_FUNC_N must match six-bit function codes");
   end

   // ==========================================================
   // Decoding helpers
   function automatic rpsm_word_t regMask(input rpsm_idx_t idx);
      rpsm_word_t m;
      m = `RPSM_MASK_OUT_PAIR;
      unique case (idx)
         `RPSM_IDX_SS: m = `RPSM_MASK_LO_IN;
         `RPSM_IDX_CAN: m = HAS_CAN ? `RPSM_MASK_LO_IN : `RPSM_MASK_NONE;
         `RPSM_IDX_SYNC: m = `RPSM_MASK_HI_IN;
         `RPSM_IDX_DTA: m = `RPSM_MASK_HI_IN;
         `RPSM_IDX_DTB: m = `RPSM_MASK_BOTH_IN;
         `RPSM_IDX_OUT7: m = `RPSM_MASK_OUT_HI;
         `RPSM_IDX_OUT8: m = `RPSM_MASK_OUT_HI;
         `RPSM_IDX_OUT9: m = `RPSM_MASK_OUT_LO;
         default: m = (idx < `RPSM_NUM_REGS) ? `RPSM_MASK_OUT_PAIR : `RPSM_MASK_NONE;
      endcase
      return m;
   endfunction

   function automatic rpsm_idx_t addrIdx(input logic [ADDR_W-1:0] a);
      return a[`RPSM_ADDR_LSB +: `RPSM_IDX_W];
   endfunction

   function automatic logic addrMapped(input logic [ADDR_W-1:0] a);
      logic ok;
      ok = (a[`RPSM_ADDR_LSB-1:0] == '0) && (addrIdx(a) < `RPSM_NUM_REGS);
      if (ADDR_W > `RPSM_IDX_W + `RPSM_ADDR_LSB)
         ok = ok && (a >> (`RPSM_IDX_W + `RPSM_ADDR_LSB)) == '0;
      return ok;
   endfunction

   // Output pin k: register and field position
   function automatic rpsm_idx_t pinReg(input int k);
      rpsm_idx_t r;
      if (k < `RPSM_PAIRED_PINS)
         r = `RPSM_IDX_OUT0 + rpsm_idx_t'(k / 2);
      else if (k == `RPSM_PIN_97)
         r = `RPSM_IDX_OUT7;
      else if (k == `RPSM_PIN_118)
         r = `RPSM_IDX_OUT8;
      else
         r = `RPSM_IDX_OUT9;
      return r;
   endfunction

   function automatic int pinLsb(input int k);
      if (k < `RPSM_PAIRED_PINS)
         return (k % 2 == 1) ? `RPSM_HI_LSB : `RPSM_LO_LSB;
      else if (k == `RPSM_PIN_120)
         return `RPSM_LO_LSB;
      else
         return `RPSM_HI_LSB;
   endfunction

   // ==========================================================
   // APB slave
   rpsm_word_t mapReg [`RPSM_NUM_REGS];
   logic setupPhase;
   logic writeDone;
   rpsm_idx_t accIdx;
   rpsm_word_t wrMask;
   rpsm_word_t rdWord;

   assign setupPhase = psel && !penable;
   assign writeDone = psel && penable && pready && pwrite && addrMapped(paddr);
   assign accIdx = addrIdx(paddr);
   assign wrMask = regMask(accIdx) & {{8{pstrb[1]}}, {8{pstrb[0]}}};
   assign rdWord = addrMapped(paddr) ? (mapReg[accIdx] & regMask(accIdx)) : `RPSM_REG_RESET;

   // Zero wait: answer rises in the access cycle
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= '0;
      end
      else
      begin
         pready <= setupPhase;
         pslverr <= setupPhase && !addrMapped(paddr);
         prdata <= setupPhase && !pwrite ? {16'h0000, rdWord} : '0;
      end
   end

   // Register file; write lands at the completing edge
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         for (int i = 0; i < `RPSM_NUM_REGS; i++)
            mapReg[i] <= `RPSM_REG_RESET;
      end
      else if (writeDone)
      begin
         mapReg[accIdx] <= (mapReg[accIdx] & ~wrMask) | (pwdata[15:0] & wrMask);
      end
   end

   // ==========================================================
   // Input routing
   rpsm_in_sel_t inSel [RPSM_IN_COUNT];
   logic [RPSM_IN_COUNT-1:0] inRouted;
   logic [IN_SRC_N-1:0] inSrc;

   assign inSrc = {remappablePinIn[IN_SRC_N-1:2], comparatorOneOutput, 1'b0};
   assign inSel[RPSM_IN_SS] = mapReg[`RPSM_IDX_SS][`RPSM_LO_LSB +: 7];
   assign inSel[RPSM_IN_CAN] = HAS_CAN ? mapReg[`RPSM_IDX_CAN][`RPSM_LO_LSB +: 7] : `RPSM_CODE_GND;
   assign inSel[RPSM_IN_SYNC] = mapReg[`RPSM_IDX_SYNC][`RPSM_HI_LSB +: 7];
   assign inSel[RPSM_IN_DT1] = mapReg[`RPSM_IDX_DTA][`RPSM_HI_LSB +: 7];
   assign inSel[RPSM_IN_DT2] = mapReg[`RPSM_IDX_DTB][`RPSM_LO_LSB +: 7];
   assign inSel[RPSM_IN_DT3] = mapReg[`RPSM_IDX_DTB][`RPSM_HI_LSB +: 7];

   genvar gi;
   generate
      for (gi = 0; gi < RPSM_IN_COUNT; gi++)
      begin : g_in
         rpsm_sel_mux #(.SEL_W(7), .SRC_N(IN_SRC_N)) u_mux
         (
            .sys_clk(sys_clk),
            .reset(reset),
            .sel(inSel[gi]),
            .src(inSrc),
            .outBit(inRouted[gi]),
            .selActive()
         );
      end
   endgenerate

   assign serialTwoSlaveSelect = inRouted[RPSM_IN_SS];
   assign canReceiveInput = inRouted[RPSM_IN_CAN];
   assign pwmSyncInputOne = inRouted[RPSM_IN_SYNC];
   assign deadtimeCompInputOne = inRouted[RPSM_IN_DT1];
   assign deadtimeCompInputTwo = inRouted[RPSM_IN_DT2];
   assign deadtimeCompInputThree = inRouted[RPSM_IN_DT3];

   // ==========================================================
   // Output routing; code zero leaves the pin undriven
   rpsm_out_sel_t outSel [`RPSM_OUT_PINS];
   logic [OUT_FUNC_N-1:0] outSrc;

   assign outSrc = {peripheralFunctionOut[OUT_FUNC_N-1:1], 1'b0};

   generate
      for (gi = 0; gi < `RPSM_OUT_PINS; gi++)
      begin : g_out
         assign outSel[gi] = mapReg[pinReg(gi)][pinLsb(gi) +: 6];
         rpsm_sel_mux #(.SEL_W(6), .SRC_N(OUT_FUNC_N)) u_mux
         (
            .sys_clk(sys_clk),
            .reset(reset),
            .sel(outSel[gi]),
            .src(outSrc),
            .outBit(remappablePinOut[gi]),
            .selActive(remappablePinOutEn[gi])
         );
      end
   endgenerate

   // ==========================================================
   // Checks
   sequence apb_write_s;
      psel && penable && pready && pwrite && addrMapped(paddr);
   endsequence

   sequence apb_setup_s;
      psel && !penable;
   endsequence

   unmapped_error_a: assert property (@(posedge sys_clk) disable iff (reset)
      apb_setup_s and !addrMapped(paddr) |=> pready && pslverr)
      else $error("unmapped access not flagged");

   ss_field_a: assert property (@(posedge sys_clk) disable iff (reset)
      mapReg[`RPSM_IDX_SS][15:7] == 9'h000)
      else $error("slave select register holds bits above its field");

   ground_route_a: assert property (@(posedge sys_clk) disable iff (reset)
      inSel[RPSM_IN_SS] == `RPSM_CODE_GND |=> !serialTwoSlaveSelect)
      else $error("code zero did not give ground");

   comp_route_a: assert property (@(posedge sys_clk) disable iff (reset)
      inSel[RPSM_IN_DT2] == `RPSM_CODE_CMP |=> deadtimeCompInputTwo == $past(comparatorOneOutput))
      else $error("code one did not follow comparator one");

   pin_max_route_a: assert property (@(posedge sys_clk) disable iff (reset)
      inSel[RPSM_IN_SYNC] == `RPSM_CODE_PIN_MAX |=>
      pwmSyncInputOne == $past(remappablePinIn[IN_SRC_N-1]))
      else $error("highest code did not follow pin 121");

   can_absent_a: assert property (@(posedge sys_clk) disable iff (reset)
      !HAS_CAN |-> !canReceiveInput && mapReg[`RPSM_IDX_CAN] == `RPSM_REG_RESET)
      else $error("CAN source active on a variant without CAN");

   sync_low_byte_a: assert property (@(posedge sys_clk) disable iff (reset)
      mapReg[`RPSM_IDX_SYNC][7:0] == 8'h00)
      else $error("sync register low byte not empty");

   deadtime_route_a: assert property (@(posedge sys_clk) disable iff (reset)
      inSel[RPSM_IN_DT3] == `RPSM_CODE_CMP && inSel[RPSM_IN_DT1] == `RPSM_CODE_GND |=>
      deadtimeCompInputThree == $past(comparatorOneOutput) && !deadtimeCompInputOne)
      else $error("dead-time inputs misrouted");

   out_enable_a: assert property (@(posedge sys_clk) disable iff (reset)
      ##1 remappablePinOutEn[0] == ($past(outSel[0]) != `RPSM_OUT_CODE_OFF))
      else $error("output enable does not follow function code");

   pin120_field_a: assert property (@(posedge sys_clk) disable iff (reset)
      mapReg[`RPSM_IDX_OUT9][15:6] == 10'h000 && mapReg[`RPSM_IDX_OUT7][7:0] == 8'h00)
      else $error("single-pin output register has stray bits");

   read_reserved_a: assert property (@(posedge sys_clk) disable iff (reset)
      apb_setup_s and !pwrite and accIdx == `RPSM_IDX_DTB |=> prdata[31:15] == '0 && !prdata[7])
      else $error("unimplemented bits read as one");

   reset_zero_a: assert property (@(posedge sys_clk)
      reset |=> mapReg[`RPSM_IDX_DTB] == `RPSM_REG_RESET && !remappablePinOutEn[0])
      else $error("select state not cleared by reset");

   write_apply_a: assert property (@(posedge sys_clk) disable iff (reset)
      apb_write_s and accIdx == `RPSM_IDX_SS and pstrb[0] |=>
      inSel[RPSM_IN_SS] == $past(pwdata[6:0]) ##1
      serialTwoSlaveSelect == $past(inSrc[inSel[RPSM_IN_SS]]))
      else $error("new selection not applied in time");
endmodule
`default_nettype wire

// ---- test/rpsm_far_model.sv ----
`default_nettype none
module rpsm_far_model
(
   input wire logic sys_clk,
   input wire logic reset,
   output logic [121:0] pinLevel,
   output logic cmpLevel,
   output logic [63:0] funcLevel
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // Sources
   // Every level moves each cycle so stale routing cannot pass
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         pinLevel <= {61{2'b10}};
         cmpLevel <= 1'b0;
         funcLevel <= {32{2'b01}};
      end
      else
      begin
         // Rotating an even-length alternating pattern flips every bit
         pinLevel <= {pinLevel[120:0], pinLevel[121]};
         cmpLevel <= ~cmpLevel;
         funcLevel <= {funcLevel[62:0], funcLevel[63]};
      end
   end
endmodule
`default_nettype wire

// ---- test/rpsm_top_test.sv ----
`default_nettype none
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin n_fail++; \
   $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module rpsm_top_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rdWord;
   logic [3:0] pstrb = 4'h0;
   logic pready, pslverr, errBit, cmpLevel, cmpPrev;
   logic [121:0] pinLevel, pinPrev;
   logic [63:0] funcLevel, funcPrev;
   logic [5:0] routed;
   logic [16:0] pinOut, pinOutEn;
   logic [6:0] inCode;
   logic [5:0] loCode, hiCode;
   logic [15:0] maskTab [15] = '{16'h007F, 16'h007F, 16'h7F00, 16'h7F00, 16'h7F7F, 16'h3F3F, 16'h3F3F,
      16'h3F3F, 16'h3F3F, 16'h3F3F, 16'h3F3F, 16'h3F3F, 16'h3F00, 16'h3F00, 16'h003F};
   logic [6:0] codeTab [6] = '{7'h00, 7'h01, 7'h02, 7'h3C, 7'h79, 7'h7A};
   int n_fail = 0, checks = 0, cycles = 0;

   rpsm_top #(.HAS_CAN(1'b1)) rpsm_top_i (.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .remappablePinIn(pinLevel), .comparatorOneOutput(cmpLevel),
      .peripheralFunctionOut(funcLevel), .serialTwoSlaveSelect(routed[5]), .canReceiveInput(routed[4]),
      .pwmSyncInputOne(routed[3]), .deadtimeCompInputOne(routed[2]), .deadtimeCompInputTwo(routed[1]),
      .deadtimeCompInputThree(routed[0]), .remappablePinOut(pinOut), .remappablePinOutEn(pinOutEn));
   rpsm_far_model rpsm_far_model_i (.sys_clk(sys_clk), .reset(reset), .pinLevel(pinLevel),
      .cmpLevel(cmpLevel), .funcLevel(funcLevel));

   // ==========================================================
   // Clock, source history, timeout
   always #10 sys_clk = ~sys_clk;
   always @(posedge sys_clk)
   begin
      pinPrev <= pinLevel;
      cmpPrev <= cmpLevel;
      funcPrev <= funcLevel;
      cycles <= cycles + 1;
      if (cycles == 4000)
      begin
         n_fail++;
         summarize();
      end
   end

   // ==========================================================
   // Helpers
   function automatic logic inExp(input logic [6:0] c);
      if (c == 7'h00) return 1'b0;
      if (c == 7'h01) return cmpPrev;
      if (c <= 7'h79) return pinPrev[c];
      return 1'b0;
   endfunction

   task automatic apb(input logic wr, input logic [11:0] addr, input logic [15:0] data, input logic [1:0] strb);
      int n;
      n = 0;
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= {16'h0000, data};
      pstrb <= {2'b00, strb};
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1 && n < 20)
      begin
         n++;
         @(posedge sys_clk);
      end
      `CHK("bus answer", 1'b1, pready)
      rdWord = prdata;
      errBit = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic chkPin(input int p, input logic [5:0] code);
      `CHK("pin enable", code != 6'h00, pinOutEn[p])
      if (code != 6'h00)
         `CHK("pin level", funcPrev[code], pinOut[p])
   endtask

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // ==========================================================
   // Tests
   initial
   begin
      repeat (5) @(posedge sys_clk);
      reset <= 1'b0;
      for (int i = 0; i < 15; i++)
      begin
         apb(1'b0, 12'(i * 4), 16'h0000, 2'b00);
         `CHK("reset value", 32'h0, rdWord)
      end
      $display("test reset values done");
      for (int i = 0; i < 15; i++)
      begin
         apb(1'b1, 12'(i * 4), 16'hFFFF, 2'b11);
         apb(1'b0, 12'(i * 4), 16'h0000, 2'b00);
         `CHK("field mask", {16'h0, maskTab[i]}, rdWord)
         `CHK("no error", 1'b0, errBit)
      end
      reset <= 1'b1;
      repeat (2) @(posedge sys_clk);
      reset <= 1'b0;
      apb(1'b0, 12'h010, 16'h0000, 2'b00);
      `CHK("reset clears", 32'h0, rdWord)
      apb(1'b0, 12'h038, 16'h0000, 2'b00);
      `CHK("reset clears out", 32'h0, rdWord)
      $display("test field masks done");
      for (int j = 0; j < 6; j++)
      begin
         inCode = codeTab[j];
         apb(1'b1, 12'h000, {9'h0, inCode}, 2'b11);
         apb(1'b1, 12'h004, {9'h0, inCode}, 2'b11);
         apb(1'b1, 12'h008, {1'b0, inCode, 8'h00}, 2'b11);
         apb(1'b1, 12'h00C, {1'b0, inCode, 8'h00}, 2'b11);
         apb(1'b1, 12'h010, {1'b0, inCode, 1'b0, inCode}, 2'b11);
         @(posedge sys_clk);
         #1;
         `CHK("input routing", {6{inExp(inCode)}}, routed)
      end
      apb(1'b1, 12'h00C, 16'h0000, 2'b11);
      apb(1'b1, 12'h010, 16'h0100, 2'b11);
      @(posedge sys_clk);
      #1;
      `CHK("dead-time split", {2'b00, cmpPrev}, routed[2:0])
      $display("test input routing done");
      for (int k = 0; k < 10; k++)
      begin
         loCode = 6'(k * 5);
         hiCode = 6'(63 - k);
         apb(1'b1, 12'((k + 5) * 4), {2'b00, hiCode, 2'b00, loCode}, 2'b11);
         @(posedge sys_clk);
         #1;
         if (k < 7 || k == 9)
            chkPin(k < 7 ? 2 * k : 16, loCode);
         if (k < 9)
            chkPin(k < 7 ? 2 * k + 1 : k + 7, hiCode);
      end
      $display("test output routing done");
      apb(1'b1, 12'h018, 16'h0000, 2'b01);
      apb(1'b0, 12'h018, 16'h0000, 2'b00);
      `CHK("low byte strobe", 32'h3E00, rdWord)
      `CHK("other field kept", 2'b10, pinOutEn[3:2])
      $display("test byte strobe done");
      apb(1'b1, 12'h03C, 16'hFFFF, 2'b11);
      `CHK("unmapped write error", 1'b1, errBit)
      apb(1'b0, 12'h03C, 16'h0000, 2'b00);
      `CHK("unmapped read error", 1'b1, errBit)
      `CHK("unmapped read data", 32'h0, rdWord)
      apb(1'b1, 12'h002, 16'h0000, 2'b11);
      `CHK("misaligned write error", 1'b1, errBit)
      apb(1'b0, 12'h000, 16'h0000, 2'b00);
      `CHK("misaligned write ignored", 32'h007A, rdWord)
      $display("test unmapped access done");
      summarize();
   end
endmodule
`default_nettype wire
